// file: interlock_pkg.sv
`default_nettype none

package interlock_pkg;

	// =========================================================
	// Setting addresses on the parameter port
	// =========================================================
	localparam logic [15:0] SPEED_SRC_ADDR  = 16'h0180;
	localparam logic [15:0] DIR_SRC_ADDR    = 16'h0181;
	localparam logic [15:0] SPEED_PRIO_ADDR = 16'h02a7;
	localparam logic [15:0] OUT_FUNC_A_ADDR = 16'h0420;
	localparam logic [15:0] OUT_FUNC_B_ADDR = 16'h0421;

	// =========================================================
	// Values after reset and limits
	// =========================================================
	localparam logic [15:0] DIR_SRC_RESET    = 16'h0001;
	localparam logic [15:0] SPEED_SRC_RESET  = 16'h0000;
	localparam logic [15:0] SPEED_PRIO_RESET = 16'h0000;
	localparam logic [15:0] OUT_FUNC_RESET   = 16'h0000;
	localparam logic [15:0] SETTING_MAX      = 16'h0003;
	localparam logic [15:0] FUNC_BB_CLOSED   = 16'h002e;
	localparam logic [15:0] FUNC_BB_OPEN     = 16'h002f;
	localparam int          SYNC_STAGES      = 2;

	// =========================================================
	// Enumerations
	// =========================================================
	typedef enum logic [1:0] {
		DIR_KEYPAD   = 2'b00,
		DIR_TERMINAL = 2'b01,
		DIR_SERIAL   = 2'b10,
		DIR_OPTION   = 2'b11
	} dir_src_e;

	typedef enum logic [1:0] {
		SPD_PRESET = 2'b00,
		SPD_ANALOG = 2'b01,
		SPD_SERIAL = 2'b10,
		SPD_OPTION = 2'b11
	} speed_src_e;

	typedef enum logic [2:0] {
		REF_NONE    = 3'b000,
		REF_PRESET  = 3'b001,
		REF_ANALOG  = 3'b010,
		REF_SERIAL  = 3'b011,
		REF_OPTION  = 3'b100,
		REF_SERVICE = 3'b101
	} ref_sel_e;

	typedef enum logic [1:0] {
		ST_IDLE      = 2'b00,
		ST_WAIT_CONF = 2'b01,
		ST_UP        = 2'b10,
		ST_DOWN      = 2'b11
	} travel_state_e;

	// =========================================================
	// Carriers
	// =========================================================
	typedef struct packed {
		logic       baseblock_input_a;
		logic       baseblock_input_b;
		logic       up_command_terminal;
		logic       down_command_terminal;
		logic       speed_select;
		logic [2:0] speed_step;
		logic       service_speed;
		logic       contactor_confirm;
		logic       key_run;
		logic       key_stop;
		logic       key_fwd_rev;
		logic       analog_present;
	} contact_in_s;

	typedef struct packed {
		logic up;
		logic down;
	} dir_cmd_s;

endpackage

`default_nettype wire

// file: contact_sync.sv
`timescale 1ns/1ps
`default_nettype none

module contact_sync
	import interlock_pkg::*;
#(
	parameter int WIDTH = 1
) (
	input  wire logic             clock_i,
	input  wire logic             reset_i,
	input  wire logic [WIDTH-1:0] async_i,
	output logic      [WIDTH-1:0] sync_o
);

	// First stage feeds only the second stage
	logic [WIDTH-1:0] meta_q;

	always_ff @(posedge clock_i) begin
		if (reset_i) begin
			meta_q <= '0;
			sync_o <= '0;
		end else begin
			meta_q <= async_i;
			sync_o <= meta_q;
		end
	end

endmodule

`default_nettype wire

// file: travel_command_interlock.sv
`timescale 1ns/1ps
`default_nettype none

module travel_command_interlock
	import interlock_pkg::*;
(
	input  wire logic        clock_i,
	input  wire logic        reset_i,
	input  wire contact_in_s contacts_i,
	input  wire dir_cmd_s    serial_dir_i,
	input  wire dir_cmd_s    option_dir_i,
	input  wire logic        contactor_confirm_enable_i,
	input  wire logic        option_analog_fitted_i,
	input  wire logic        param_wr_i,
	input  wire logic        param_rd_i,
	input  wire logic [15:0] param_addr_i,
	input  wire logic [15:0] param_wdata_i,
	output logic      [15:0] param_rdata_o,
	output logic             param_reject_o,
	output logic             monitor_out_a_o,
	output logic             monitor_out_b_o,
	output logic             travel_up_o,
	output logic             travel_down_o,
	output logic             wait_contactor_o,
	output logic             running_o,
	output ref_sel_e         ref_select_o,
	output logic      [2:0]  speed_step_o,
	output logic             analog_channel_o
);

	// =========================================================
	// Helpers
	// =========================================================
	function automatic logic monitor_level(
		input logic [15:0] func,
		input logic        bb_a,
		input logic        bb_b
	);
		logic lvl;
		lvl = 1'b0;
		// Baseblock monitor decode
		// both closed polarity
		if (func == FUNC_BB_CLOSED) begin
			lvl = bb_a & bb_b;
		end
		if (func == FUNC_BB_OPEN) begin
			lvl = ~bb_a | ~bb_b;
		end
		return lvl;
	endfunction

	function automatic logic in_range(input logic [15:0] value);
		return value <= SETTING_MAX;
	endfunction

	// =========================================================
	// Input synchronisation
	// =========================================================
	contact_in_s contacts_sync;
	dir_cmd_s    serial_dir_sync;
	dir_cmd_s    option_dir_sync;
	logic        confirm_en_sync;
	logic        analog_fitted_sync;

	contact_sync #(
		.WIDTH ($bits(contact_in_s) + 2 * $bits(dir_cmd_s) + 2)
	) u_sync (
		.clock_i (clock_i),
		.reset_i (reset_i),
		.async_i ({contacts_i, serial_dir_i, option_dir_i,
		           contactor_confirm_enable_i, option_analog_fitted_i}),
		.sync_o  ({contacts_sync, serial_dir_sync, option_dir_sync,
		           confirm_en_sync, analog_fitted_sync})
	);

	// =========================================================
	// Settings
	// =========================================================
	dir_src_e      dir_src_q;
	speed_src_e    speed_src_q;
	logic [1:0]    speed_prio_q;
	logic [15:0]   out_func_a_q;
	logic [15:0]   out_func_b_q;
	travel_state_e state_q;
	travel_state_e state_d;
	logic          busy;
	logic          wr_locked;
	logic          wr_bad_value;

	assign busy = state_q != ST_IDLE;

	assign wr_locked = busy && (param_addr_i == DIR_SRC_ADDR ||
	                            param_addr_i == SPEED_SRC_ADDR ||
	                            param_addr_i == SPEED_PRIO_ADDR);

	assign wr_bad_value = !in_range(param_wdata_i) &&
	                      (param_addr_i == DIR_SRC_ADDR ||
	                       param_addr_i == SPEED_SRC_ADDR ||
	                       param_addr_i == SPEED_PRIO_ADDR);

	always_ff @(posedge clock_i) begin
		if (reset_i) begin
			dir_src_q    <= dir_src_e'(DIR_SRC_RESET[1:0]);
			speed_src_q  <= speed_src_e'(SPEED_SRC_RESET[1:0]);
			speed_prio_q <= SPEED_PRIO_RESET[1:0];
			out_func_a_q <= OUT_FUNC_RESET;
			out_func_b_q <= OUT_FUNC_RESET;
		end else if (param_wr_i && !wr_locked && !wr_bad_value) begin
			unique case (param_addr_i)
				DIR_SRC_ADDR: begin
					dir_src_q <= dir_src_e'(param_wdata_i[1:0]);
				end
				SPEED_SRC_ADDR: begin
					speed_src_q <= speed_src_e'(param_wdata_i[1:0]);
				end
				SPEED_PRIO_ADDR: begin
					speed_prio_q <= param_wdata_i[1:0];
				end
				OUT_FUNC_A_ADDR: begin
					out_func_a_q <= param_wdata_i;
				end
				OUT_FUNC_B_ADDR: begin
					out_func_b_q <= param_wdata_i;
				end
				default: begin
				end
			endcase
		end
	end

	// Unmapped writes are not flagged; only refused settings are
	always_ff @(posedge clock_i) begin
		if (reset_i) begin
			param_reject_o <= 1'b0;
		end else begin
			param_reject_o <= param_wr_i && (wr_locked || wr_bad_value);
		end
	end

	always_ff @(posedge clock_i) begin
		if (reset_i) begin
			param_rdata_o <= 16'h0000;
		end else if (param_rd_i) begin
			unique case (param_addr_i)
				DIR_SRC_ADDR:    param_rdata_o <= {14'h0000, dir_src_q};
				SPEED_SRC_ADDR:  param_rdata_o <= {14'h0000, speed_src_q};
				SPEED_PRIO_ADDR: param_rdata_o <= {14'h0000, speed_prio_q};
				OUT_FUNC_A_ADDR: param_rdata_o <= out_func_a_q;
				OUT_FUNC_B_ADDR: param_rdata_o <= out_func_b_q;
				default:         param_rdata_o <= 16'h0000;
			endcase
		end
	end

	// =========================================================
	// Operator keypad latch
	// =========================================================
	logic key_run_last_q;
	logic key_stop_last_q;
	logic key_rev_last_q;
	logic key_run_q;
	logic key_reverse_q;

	always_ff @(posedge clock_i) begin
		if (reset_i) begin
			key_run_last_q  <= 1'b0;
			key_stop_last_q <= 1'b0;
			key_rev_last_q  <= 1'b0;
		end else begin
			key_run_last_q  <= contacts_sync.key_run;
			key_stop_last_q <= contacts_sync.key_stop;
			key_rev_last_q  <= contacts_sync.key_fwd_rev;
		end
	end

	// Stop key wins over run key pressed in the same cycle
	always_ff @(posedge clock_i) begin
		if (reset_i) begin
			key_run_q <= 1'b0;
		end else if (dir_src_q != DIR_KEYPAD) begin
			key_run_q <= 1'b0;
		end else if (contacts_sync.key_stop && !key_stop_last_q) begin
			key_run_q <= 1'b0;
		end else if (contacts_sync.key_run && !key_run_last_q) begin
			key_run_q <= 1'b1;
		end
	end

	// Direction may only be reversed while stopped
	always_ff @(posedge clock_i) begin
		if (reset_i) begin
			key_reverse_q <= 1'b0;
		end else if (contacts_sync.key_fwd_rev && !key_rev_last_q && !key_run_q) begin
			key_reverse_q <= ~key_reverse_q;
		end
	end

	// =========================================================
	// Direction command selection
	// =========================================================
	logic cmd_up;
	logic cmd_down;

	always_comb begin
		cmd_up   = 1'b0;
		cmd_down = 1'b0;
		unique case (dir_src_q)
			DIR_KEYPAD: begin
				cmd_up   = key_run_q & ~key_reverse_q;
				cmd_down = key_run_q & key_reverse_q;
			end
			DIR_TERMINAL: begin
				cmd_up   = contacts_sync.up_command_terminal;
				cmd_down = contacts_sync.down_command_terminal;
			end
			DIR_SERIAL: begin
				cmd_up   = serial_dir_sync.up;
				cmd_down = serial_dir_sync.down;
			end
			DIR_OPTION: begin
				cmd_up   = option_dir_sync.up;
				cmd_down = option_dir_sync.down;
			end
		endcase
	end

	// =========================================================
	// Speed reference selection
	// =========================================================
	logic     steps_any;
	logic     speed_ok;
	ref_sel_e ref_sel;

	assign steps_any = |contacts_sync.speed_step;

	// priority three needs a step input
	assign speed_ok = contacts_sync.speed_select &&
	                  (speed_prio_q != 2'd3 || steps_any);

	always_comb begin
		ref_sel = REF_NONE;
		if (contacts_sync.speed_select) begin
			unique case (speed_src_q)
				SPD_PRESET: begin
					if (speed_prio_q inside {2'd1, 2'd2} && contacts_sync.analog_present) begin
						ref_sel = REF_ANALOG;
					end else begin
						ref_sel = REF_PRESET;
					end
				end
				SPD_ANALOG: begin
					if (speed_prio_q == 2'd0 && contacts_sync.service_speed) begin
						ref_sel = REF_SERVICE;
					end else begin
						ref_sel = REF_ANALOG;
					end
				end
				SPD_SERIAL, SPD_OPTION: begin
					if (speed_prio_q inside {2'd1, 2'd2} && steps_any) begin
						ref_sel = REF_PRESET;
					end else if (speed_src_q == SPD_SERIAL) begin
						ref_sel = REF_SERIAL;
					end else begin
						ref_sel = REF_OPTION;
					end
				end
			endcase
		end
	end

	always_ff @(posedge clock_i) begin
		if (reset_i) begin
			ref_select_o     <= REF_NONE;
			speed_step_o     <= 3'h0;
			analog_channel_o <= 1'b0;
		end else begin
			ref_select_o     <= ref_sel;
			speed_step_o     <= contacts_sync.speed_step;
			analog_channel_o <= analog_fitted_sync;
		end
	end

	// =========================================================
	// Travel start and stop
	// =========================================================
	logic bb_enabled;
	logic start_ok;
	logic confirm_ok;

	assign bb_enabled = contacts_sync.baseblock_input_a & contacts_sync.baseblock_input_b;

	assign start_ok = speed_ok && bb_enabled && (cmd_up ^ cmd_down);

	assign confirm_ok = !confirm_en_sync || contacts_sync.contactor_confirm;

	always_comb begin
		state_d = state_q;
		unique case (state_q)
			ST_IDLE: begin
				if (start_ok) begin
					if (!confirm_ok) begin
						state_d = ST_WAIT_CONF;
					end else if (cmd_up) begin
						state_d = ST_UP;
					end else begin
						state_d = ST_DOWN;
					end
				end
			end
			ST_WAIT_CONF: begin
				if (!start_ok) begin
					state_d = ST_IDLE;
				end else if (confirm_ok) begin
					state_d = cmd_up ? ST_UP : ST_DOWN;
				end
			end
			ST_UP: begin
				if (!cmd_up || !speed_ok || !bb_enabled) begin
					state_d = ST_IDLE;
				end
			end
			ST_DOWN: begin
				if (!cmd_down || !speed_ok || !bb_enabled) begin
					state_d = ST_IDLE;
				end
			end
		endcase
	end

	always_ff @(posedge clock_i) begin
		if (reset_i) begin
			state_q <= ST_IDLE;
		end else begin
			state_q <= state_d;
		end
	end

	// Outputs follow the next state so they track the state register
	always_ff @(posedge clock_i) begin
		if (reset_i) begin
			travel_up_o      <= 1'b0;
			travel_down_o    <= 1'b0;
			wait_contactor_o <= 1'b0;
			running_o        <= 1'b0;
		end else begin
			travel_up_o      <= state_d == ST_UP;
			travel_down_o    <= state_d == ST_DOWN;
			wait_contactor_o <= state_d == ST_WAIT_CONF;
			running_o        <= state_d != ST_IDLE;
		end
	end

	// =========================================================
	// Baseblock monitor outputs
	// =========================================================
	// Uses synced inputs and a registered output; contact bounce is not filtered and passes through to the monitor
	always_ff @(posedge clock_i) begin
		if (reset_i) begin
			monitor_out_a_o <= 1'b0;
			monitor_out_b_o <= 1'b0;
		end else begin
			monitor_out_a_o <= monitor_level(out_func_a_q,
			                                 contacts_sync.baseblock_input_a,
			                                 contacts_sync.baseblock_input_b);
			monitor_out_b_o <= monitor_level(out_func_b_q,
			                                 contacts_sync.baseblock_input_a,
			                                 contacts_sync.baseblock_input_b);
		end
	end

endmodule

`default_nettype wire

// file: travel_command_interlock_assertions.sv
`timescale 1ns/1ps
`default_nettype none

module travel_command_interlock_checker
	import interlock_pkg::*;
(
	input  wire logic        clock_i,
	input  wire logic        reset_i,
	input  wire contact_in_s contacts_i,
	input  wire logic        contactor_confirm_enable_i,
	input  wire logic        param_wr_i,
	input  wire logic [15:0] param_addr_i,
	input  wire logic [15:0] param_wdata_i,
	input  wire logic        param_reject_o,
	input  wire logic        monitor_out_a_o,
	input  wire logic        monitor_out_b_o,
	input  wire logic        travel_up_o,
	input  wire logic        travel_down_o,
	input  wire logic        running_o
);
	default clocking @(posedge clock_i); endclocking
	default disable iff (reset_i);

	logic [2:0]  age_q;
	logic [15:0] fa_q;
	logic [15:0] fb_q;
	logic        bb;
	logic        sel;
	logic        conf;
	logic        dir_wr;

	assign bb     = contacts_i.baseblock_input_a & contacts_i.baseblock_input_b;
	assign sel    = contacts_i.speed_select;
	assign conf   = contacts_i.contactor_confirm;
	assign dir_wr = param_wr_i && param_addr_i == DIR_SRC_ADDR;

	// Synchronisers still hold reset values for a few edges
	always_ff @(posedge clock_i) begin
		if (reset_i)
			age_q <= 3'h0;
		else if (age_q != 3'h5)
			age_q <= age_q + 3'h1;
	end

	always_ff @(posedge clock_i) begin
		if (reset_i) begin
			fa_q <= OUT_FUNC_RESET;
			fb_q <= OUT_FUNC_RESET;
		end else if (param_wr_i && param_addr_i == OUT_FUNC_A_ADDR)
			fa_q <= param_wdata_i;
		else if (param_wr_i && param_addr_i == OUT_FUNC_B_ADDR)
			fb_q <= param_wdata_i;
	end

	property p_mon_a;
		age_q == 3'h5 && fa_q == FUNC_BB_CLOSED && $past(fa_q, 3) == FUNC_BB_CLOSED
			|-> monitor_out_a_o == $past(bb, 3);
	endproperty
	a_mon_a: assert property (p_mon_a) else $error("monitor A wrong");

	property p_mon_b;
		age_q == 3'h5 && fb_q == FUNC_BB_OPEN && $past(fb_q, 3) == FUNC_BB_OPEN
			|-> monitor_out_b_o == !$past(bb, 3);
	endproperty
	a_mon_b: assert property (p_mon_b) else $error("monitor B wrong");

	property p_no_speed;
		age_q == 3'h5 && !$past(sel, 3) |-> !running_o && !travel_up_o && !travel_down_o;
	endproperty
	a_no_speed: assert property (p_no_speed) else $error("travel without speed");

	property p_no_bb;
		age_q == 3'h5 && !$past(bb, 3) |-> !running_o && !travel_up_o && !travel_down_o;
	endproperty
	a_no_bb: assert property (p_no_bb) else $error("travel in baseblock");

	property p_confirm;
		$rose(travel_up_o || travel_down_o) && contactor_confirm_enable_i && $past(contactor_confirm_enable_i, 3)
			|-> $past(conf, 3);
	endproperty
	a_confirm: assert property (p_confirm) else $error("start before confirm");

	property p_excl;
		travel_up_o || travel_down_o |-> running_o && !(travel_up_o && travel_down_o);
	endproperty
	a_excl: assert property (p_excl) else $error("direction outputs clash");

	property p_range;
		dir_wr && param_wdata_i > SETTING_MAX |=> param_reject_o;
	endproperty
	a_range: assert property (p_range) else $error("range not refused");

	property p_busy;
		dir_wr && running_o |=> param_reject_o;
	endproperty
	a_busy: assert property (p_busy) else $error("busy write not refused");

	property p_cause;
		param_reject_o |-> $past(param_wr_i);
	endproperty
	a_cause: assert property (p_cause) else $error("reject without write");
endmodule

bind travel_command_interlock travel_command_interlock_checker chk (
	.clock_i                   (clock_i),
	.reset_i                   (reset_i),
	.contacts_i                (contacts_i),
	.contactor_confirm_enable_i(contactor_confirm_enable_i),
	.param_wr_i                (param_wr_i),
	.param_addr_i              (param_addr_i),
	.param_wdata_i             (param_wdata_i),
	.param_reject_o            (param_reject_o),
	.monitor_out_a_o           (monitor_out_a_o),
	.monitor_out_b_o           (monitor_out_b_o),
	.travel_up_o               (travel_up_o),
	.travel_down_o             (travel_down_o),
	.running_o                 (running_o)
);

`default_nettype wire

// file: elevator_controller_model.sv
`timescale 1ns/1ps
`default_nettype none

module elevator_controller_model (
	input  wire logic clock_i,
	input  wire logic reset_i,
	input  wire logic clear_i,
	input  wire logic chain_closed_i,
	input  wire logic want_up_i,
	input  wire logic want_down_i,
	input  wire logic monitor_i,
	output logic      bb_a_o,
	output logic      bb_b_o,
	output logic      up_o,
	output logic      down_o,
	output logic      fault_o
);
	logic [3:0] miss_q;

	assign bb_a_o = chain_closed_i;
	assign bb_b_o = chain_closed_i;

	always_ff @(posedge clock_i) begin
		if (reset_i || clear_i) begin
			miss_q  <= 4'h0;
			fault_o <= 1'b0;
		end else if (monitor_i != chain_closed_i) begin
			miss_q <= miss_q + 4'h1;
			if (miss_q == 4'h8)
				fault_o <= 1'b1;
		end else
			miss_q <= 4'h0;
	end

	assign up_o   = want_up_i & ~fault_o;
	assign down_o = want_down_i & ~fault_o;
endmodule

`default_nettype wire

// file: travel_command_interlock_tb_top.sv
`timescale 1ns/1ps
`default_nettype none

`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin n_errors++; \
	$display("Error at %0t: got %h expected %h", $time, (g), (e)); end end

module travel_command_interlock_tb_top
	import interlock_pkg::*;
;
	logic        clock_i, reset_i, cen, fit, pwr, prd, chain, wu, wd, clr;
	logic        bba, bbb, upt, dnt, flt, rej, mon_a, mon_b;
	logic        travel_up_o, travel_down_o, waitc, running_o, ach;
	logic [15:0] pa, pwd, param_rdata_o;
	logic [2:0]  step;
	contact_in_s ct, contacts;
	dir_cmd_s    sdir, odir;
	ref_sel_e    ref_select_o;
	int          n_errors, tests_run;
	// src prio service present step expected
	logic [11:0] tbl [7] = '{
		{2'h1, 2'h0, 1'b1, 1'b0, 3'h0, REF_SERVICE}, {2'h1, 2'h0, 1'b0, 1'b0, 3'h3, REF_ANALOG},
		{2'h0, 2'h1, 1'b0, 1'b1, 3'h0, REF_ANALOG}, {2'h0, 2'h2, 1'b0, 1'b0, 3'h0, REF_PRESET},
		{2'h2, 2'h1, 1'b0, 1'b0, 3'h2, REF_PRESET}, {2'h3, 2'h2, 1'b0, 1'b0, 3'h0, REF_OPTION},
		{2'h2, 2'h0, 1'b0, 1'b0, 3'h1, REF_SERIAL}};

	always_comb begin
		contacts = ct;
		contacts.baseblock_input_a = bba;
		contacts.baseblock_input_b = bbb;
		contacts.up_command_terminal = upt;
		contacts.down_command_terminal = dnt;
	end

	travel_command_interlock uut (.clock_i(clock_i), .reset_i(reset_i), .contacts_i(contacts),
		.serial_dir_i(sdir), .option_dir_i(odir), .contactor_confirm_enable_i(cen),
		.option_analog_fitted_i(fit), .param_wr_i(pwr), .param_rd_i(prd), .param_addr_i(pa),
		.param_wdata_i(pwd), .param_rdata_o(param_rdata_o), .param_reject_o(rej),
		.monitor_out_a_o(mon_a), .monitor_out_b_o(mon_b), .travel_up_o(travel_up_o),
		.travel_down_o(travel_down_o), .wait_contactor_o(waitc), .running_o(running_o),
		.ref_select_o(ref_select_o), .speed_step_o(step), .analog_channel_o(ach));

	elevator_controller_model ctl (.clock_i(clock_i), .reset_i(reset_i), .clear_i(clr),
		.chain_closed_i(chain), .want_up_i(wu), .want_down_i(wd), .monitor_i(mon_a),
		.bb_a_o(bba), .bb_b_o(bbb), .up_o(upt), .down_o(dnt), .fault_o(flt));

	// ==========================================
	// Access tasks
	// ==========================================
	task tk(input int n);
		repeat (n) @(posedge clock_i);
	endtask

	task wr(input logic [15:0] a, input logic [15:0] d, input logic rj);
		@(posedge clock_i);
		pwr <= 1'b1;
		pa  <= a;
		pwd <= d;
		@(posedge clock_i);
		pwr <= 1'b0;
		#1;
		`CHK(rej, rj);
		@(posedge clock_i);
	endtask

	task rd(input logic [15:0] a, input logic [15:0] e);
		@(posedge clock_i);
		prd <= 1'b1;
		pa  <= a;
		@(posedge clock_i);
		prd <= 1'b0;
		#1;
		`CHK(param_rdata_o, e);
		@(posedge clock_i);
	endtask

	// Travel outputs up, down, running after the sync delay
	task tv(input logic [2:0] e);
		tk(5);
		#1;
		`CHK({travel_up_o, travel_down_o, running_o}, e);
		@(posedge clock_i);
	endtask

	task give_verdict;
		$display("Mismatches %0d of %0d comparisons", n_errors, tests_run);
		if (n_errors == 0 && tests_run > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	initial begin
		clock_i = 1'b0;
		forever #25 clock_i = ~clock_i;
	end

	// Whole sequence needs well under 2000 cycles
	initial begin
		tk(20000);
		n_errors++;
		give_verdict();
	end

	// ==========================================
	// Tests
	// ==========================================
	initial begin
		{reset_i, chain} = 2'b11;
		{cen, fit, pwr, prd, wu, wd, clr} = 7'h0;
		{pa, pwd, ct, sdir, odir} = '0;
		n_errors = 0;
		tests_run = 0;
		tk(6);
		reset_i <= 1'b0;
		rd(DIR_SRC_ADDR, DIR_SRC_RESET);
		rd(SPEED_SRC_ADDR, SPEED_SRC_RESET);
		rd(16'h0123, 16'h0000);
		tk(12);
		ct.speed_select <= 1'b1;
		wu <= 1'b1;
		tv(3'b000);
		#1;
		`CHK(flt, 1'b1);
		wr(OUT_FUNC_A_ADDR, FUNC_BB_CLOSED, 1'b0);
		wr(OUT_FUNC_B_ADDR, FUNC_BB_OPEN, 1'b0);
		clr <= 1'b1;
		@(posedge clock_i);
		clr <= 1'b0;
		tv(3'b101);
		#1;
		`CHK({mon_a, mon_b}, 2'b10);
		wr(DIR_SRC_ADDR, 16'h0002, 1'b1);
		rd(DIR_SRC_ADDR, 16'h0001);
		chain <= 1'b0;
		tv(3'b000);
		#1;
		`CHK({mon_a, mon_b}, 2'b01);
		@(posedge clock_i);
		chain <= 1'b1;
		tv(3'b101);
		wu <= 1'b0;
		tv(3'b000);
		wd <= 1'b1;
		tv(3'b011);
		wu <= 1'b1;
		tv(3'b011);
		ct.speed_select <= 1'b0;
		tv(3'b000);
		ct.speed_select <= 1'b1;
		tv(3'b000);
		wd <= 1'b0;
		cen <= 1'b1;
		tk(5);
		#1;
		`CHK({waitc, running_o, travel_up_o}, 3'b110);
		@(posedge clock_i);
		ct.contactor_confirm <= 1'b1;
		tv(3'b101);
		{wu, cen} <= 2'b00;
		tv(3'b000);
		wr(DIR_SRC_ADDR, 16'h0004, 1'b1);
		wr(SPEED_SRC_ADDR, 16'h0004, 1'b1);
		wr(SPEED_PRIO_ADDR, 16'h0003, 1'b0);
		wu <= 1'b1;
		tv(3'b000);
		ct.speed_step <= 3'h5;
		tv(3'b101);
		#1;
		`CHK(step, 3'h5);
		@(posedge clock_i);
		ct.speed_step <= 3'h0;
		tv(3'b000);
		wr(DIR_SRC_ADDR, 16'h0000, 1'b0);
		wr(SPEED_PRIO_ADDR, 16'h0000, 1'b0);
		ct.key_run <= 1'b1;
		tk(3);
		ct.key_run <= 1'b0;
		tk(5);
		#1;
		`CHK(running_o, 1'b1);
		@(posedge clock_i);
		ct.key_stop <= 1'b1;
		tv(3'b000);
		ct.key_stop <= 1'b0;
		wr(DIR_SRC_ADDR, 16'h0002, 1'b0);
		tv(3'b000);
		sdir.up <= 1'b1;
		tv(3'b101);
		{wu, sdir} <= '0;
		tv(3'b000);
		wr(DIR_SRC_ADDR, 16'h0003, 1'b0);
		odir.down <= 1'b1;
		tv(3'b011);
		odir <= '0;
		tv(3'b000);
		for (int i = 0; i < 7; i++) begin
			wr(SPEED_SRC_ADDR, {14'h0, tbl[i][11:10]}, 1'b0);
			wr(SPEED_PRIO_ADDR, {14'h0, tbl[i][9:8]}, 1'b0);
			ct.service_speed <= tbl[i][7];
			ct.analog_present <= tbl[i][6];
			ct.speed_step <= tbl[i][5:3];
			tk(5);
			#1;
			`CHK(ref_select_o, tbl[i][2:0]);
		end
		wr(SPEED_SRC_ADDR, 16'h0001, 1'b0);
		fit <= 1'b1;
		tk(5);
		#1;
		`CHK(ach, 1'b1);
		give_verdict();
	end
endmodule

`default_nettype wire
